// *** pkg/tcs_pkg.sv ***
// types shared by the trace count and state-1 sequencer block
package tcs_pkg;

	typedef enum logic [2:0]
	{
		TCS_SEQ_IDLE,
		TCS_SEQ_STATE1,
		TCS_SEQ_STATE2,
		TCS_SEQ_STATE3,
		TCS_SEQ_FINAL
	} tcs_seq_e;

	// destination chosen for one match channel
	typedef enum logic [1:0]
	{
		TCS_DST_NONE,
		TCS_DST_STATE2,
		TCS_DST_STATE3,
		TCS_DST_FINAL
	} tcs_dst_e;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tcs_bus_req_s;

	typedef struct packed
	{
		logic       armed;
		logic [1:0] window_selector;
		logic [1:0] trigger_alignment_field;
		logic [3:0] next_state_code;
		tcs_seq_e   seq;
		logic [6:0] valid_line_tally;
		logic       trace_buffer_full_flag;
		logic [7:0] rdata;
	} tcs_state_s;

endpackage

// *** pkg/tcs_regs.svh ***
// register offsets, field positions and reset values of the trace count block
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

`define TCS_ADDR_W          8
`define TCS_DATA_W          8

`define TCS_OFS_CTRL1       8'h20
`define TCS_OFS_STATUS      8'h21
`define TCS_OFS_TRACE_CTRL  8'h22
`define TCS_OFS_COUNT       8'h26
`define TCS_OFS_WINDOW      8'h27

`define TCS_CTRL1_ARM_BIT   7
`define TCS_CTRL1_WIN_LSB   0
`define TCS_STATUS_FULL_BIT 7
`define TCS_STATUS_SEQ_LSB  0
`define TCS_TCTRL_ALIGN_LSB 0

`define TCS_WIN_STATE1      2'b00
`define TCS_WIN_STATE2      2'b01
`define TCS_WIN_STATE3      2'b10
`define TCS_WIN_MATCH       2'b11

`define TCS_ALIGN_END       2'b00
`define TCS_ALIGN_BEGIN     2'b01
`define TCS_ALIGN_MID       2'b10

`define TCS_CNT_W           7
`define TCS_CNT_RST         7'h00
`define TCS_CODE_RST        4'h0
`define TCS_ALIGN_RST       2'b00
`define TCS_WIN_RST         2'b00

`endif

// *** rtl/tcs_top.sv ***
// trace line count, full flag, state-1 sequencer and banked state control window
//
// Behaviour
// - keep a seven-bit count of valid 64-bit trace lines
// - wrap to zero sets full flag; end and mid alignment keep counting
// - writing one to the arming bit clears the count
// - of the two resets only power-on reset clears the count; system reset leaves it
// - count one is half a line; each full line adds two
// - full with zero count is 64 lines; begin alignment then disarms
// - full with nonzero count: 64 lines, oldest data overwritten
// - address 0x27 window: 00 state1, 01 state2, 10 state3, 11 match flags
// - state-1 register read when selector 00, written when 00 and disarmed
// - codes 0000..0010: any match goes to state2, state3, final
// - codes 0011..0101: only channel 2 goes to state2, state3, final
// - code 0110: ch0 state2, ch1 state3; 0111: ch1 state3, ch0 final
// - code 1000: ch0 state2, ch2 state3; 1001: ch2 state3, ch0 final
// - code 1010: ch1 state2, ch3 state3; 1011: ch3 state3, ch1 final
// - code 1100: channels 0..2 go to state2, channel 3 ignored
// - codes 1101..1111 reserved: no transition
// - simultaneous matches: lowest channel wins
// - a match leading to final state beats all others
// - alignment field 01 means begin-trigger alignment
`timescale 1ns/1ns

`include "tcs_regs.svh"

module tcs_top
#(
	parameter int NUM_CH = 4
)
(
	// clock, resets, enable
	input  wire logic                  clk_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  ce_i,
	// register port
	input  wire tcs_pkg::tcs_bus_req_s bus_i,
	output logic [7:0]                 rdata_o,
	// trace side
	input  wire logic                  store_half_i,
	input  wire logic                  trace_read_i,
	input  wire logic [NUM_CH-1:0]     match_i,
	// status
	output logic                       armed_o,
	output logic [6:0]                 line_count_o,
	output logic                       full_o,
	output tcs_pkg::tcs_seq_e          seq_state_o
);

	logic [1:0]           rst_sync;
	logic                 rst_n;
	tcs_pkg::tcs_state_s  st;
	tcs_pkg::tcs_state_s  next_st;
	tcs_pkg::tcs_dst_e    dst [NUM_CH];
	logic [NUM_CH-1:0]    hit_final;
	logic [NUM_CH-1:0]    hit_any;

	// reset release through two flops
	// release is synchronous so no flop sees a runt reset edge
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// destination for one channel under the state-1 code
	function automatic tcs_pkg::tcs_dst_e dest_of(input logic [3:0] code, input int ch);
		tcs_pkg::tcs_dst_e d;
		d = tcs_pkg::TCS_DST_NONE;
		// codes above 1100 are reserved and never move the sequencer
		case (code)
			4'h0:
			begin
				d = tcs_pkg::TCS_DST_STATE2;
			end
			4'h1:
			begin
				d = tcs_pkg::TCS_DST_STATE3;
			end
			4'h2:
			begin
				d = tcs_pkg::TCS_DST_FINAL;
			end
			4'h3:
			begin
				if (ch == 2) d = tcs_pkg::TCS_DST_STATE2;
			end
			4'h4:
			begin
				if (ch == 2) d = tcs_pkg::TCS_DST_STATE3;
			end
			4'h5:
			begin
				if (ch == 2) d = tcs_pkg::TCS_DST_FINAL;
			end
			4'h6:
			begin
				if (ch == 0) d = tcs_pkg::TCS_DST_STATE2;
				if (ch == 1) d = tcs_pkg::TCS_DST_STATE3;
			end
			4'h7:
			begin
				if (ch == 1) d = tcs_pkg::TCS_DST_STATE3;
				if (ch == 0) d = tcs_pkg::TCS_DST_FINAL;
			end
			4'h8:
			begin
				if (ch == 0) d = tcs_pkg::TCS_DST_STATE2;
				if (ch == 2) d = tcs_pkg::TCS_DST_STATE3;
			end
			4'h9:
			begin
				if (ch == 2) d = tcs_pkg::TCS_DST_STATE3;
				if (ch == 0) d = tcs_pkg::TCS_DST_FINAL;
			end
			4'hA:
			begin
				if (ch == 1) d = tcs_pkg::TCS_DST_STATE2;
				if (ch == 3) d = tcs_pkg::TCS_DST_STATE3;
			end
			4'hB:
			begin
				if (ch == 3) d = tcs_pkg::TCS_DST_STATE3;
				if (ch == 1) d = tcs_pkg::TCS_DST_FINAL;
			end
			4'hC:
			begin
				if (ch != 3) d = tcs_pkg::TCS_DST_STATE2;
			end
			default:
			begin
				d = tcs_pkg::TCS_DST_NONE;
			end
		endcase
		return d;
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			// a channel without a match never competes
			assign dst[g]       = match_i[g] ? dest_of(st.next_state_code, g)
			                                 : tcs_pkg::TCS_DST_NONE;
			assign hit_final[g] = (dst[g] == tcs_pkg::TCS_DST_FINAL);
			assign hit_any[g]   = (dst[g] != tcs_pkg::TCS_DST_NONE);
		end
	endgenerate

	always_comb
	begin
		logic              wr_ctrl1;
		logic              wr_tctrl;
		logic              wr_window;
		logic              arm_wr;
		logic              disarm_wr;
		logic              store_ok;
		logic              wrap;
		logic              seq_live;
		tcs_pkg::tcs_dst_e win;
		logic [6:0]        cnt_inc;
		next_st   = st;
		wr_ctrl1  = bus_i.wr && (bus_i.addr == `TCS_OFS_CTRL1);
		wr_tctrl  = bus_i.wr && (bus_i.addr == `TCS_OFS_TRACE_CTRL);
		wr_window = bus_i.wr && (bus_i.addr == `TCS_OFS_WINDOW);
		arm_wr    = wr_ctrl1 && bus_i.wdata[`TCS_CTRL1_ARM_BIT];
		disarm_wr = wr_ctrl1 && !bus_i.wdata[`TCS_CTRL1_ARM_BIT];
		store_ok  = st.armed && store_half_i;
		cnt_inc   = st.valid_line_tally + 7'h01;
		wrap      = (cnt_inc == `TCS_CNT_RST);
		seq_live  = 1'b0;
		win       = tcs_pkg::TCS_DST_NONE;

		// control register: arming bit and window selector
		if (wr_ctrl1)
		begin
			next_st.armed           = bus_i.wdata[`TCS_CTRL1_ARM_BIT];
			next_st.window_selector = bus_i.wdata[`TCS_CTRL1_WIN_LSB +: 2];
		end

		// alignment may not change under a running session
		if (wr_tctrl && !st.armed)
		begin
			next_st.trigger_alignment_field = bus_i.wdata[`TCS_TCTRL_ALIGN_LSB +: 2];
		end

		// only bank 00 lives here; other banks ignore the write
		if (wr_window && st.window_selector == `TCS_WIN_STATE1 && !st.armed)
		begin
			next_st.next_state_code = bus_i.wdata[3:0];
		end

		// arming starts a fresh session, disarming parks the sequencer
		if (arm_wr)
		begin
			next_st.valid_line_tally       = `TCS_CNT_RST;
			next_st.trace_buffer_full_flag = 1'b0;
			next_st.seq                    = tcs_pkg::TCS_SEQ_STATE1;
		end
		else if (disarm_wr)
		begin
			next_st.seq = tcs_pkg::TCS_SEQ_IDLE;
		end

		// trace reads leave the count alone
		if (trace_read_i)
		begin
			next_st.valid_line_tally = next_st.valid_line_tally;
		end

		// each half line adds one, so a whole line adds two
		if (store_ok && !arm_wr)
		begin
			next_st.valid_line_tally = cnt_inc;
			if (wrap)
			begin
				next_st.trace_buffer_full_flag = 1'b1;
				// begin alignment stops at exactly 64 lines
				if (st.trigger_alignment_field == `TCS_ALIGN_BEGIN)
				begin
					next_st.armed = 1'b0;
					next_st.seq   = tcs_pkg::TCS_SEQ_IDLE;
				end
			end
		end
		else if (store_ok && arm_wr && wrap)
		begin
			// hardware set wins over the clear done by the arming write
			next_st.trace_buffer_full_flag = 1'b1;
		end

		// state-1 moves only while the session stays armed past this edge,
		// otherwise a disarm would be undone by the hold below
		seq_live = st.armed && next_st.armed && !arm_wr
		           && (st.seq == tcs_pkg::TCS_SEQ_STATE1);
		if (seq_live)
		begin
			// a final-state match beats all others, else the lowest channel wins
			if (|hit_final)
			begin
				win = tcs_pkg::TCS_DST_FINAL;
			end
			else
			begin
				for (int c = NUM_CH - 1; c >= 0; c--)
				begin
					if (hit_any[c])
					begin
						win = dst[c];
					end
				end
			end
			case (win)
				tcs_pkg::TCS_DST_STATE2: next_st.seq = tcs_pkg::TCS_SEQ_STATE2;
				tcs_pkg::TCS_DST_STATE3: next_st.seq = tcs_pkg::TCS_SEQ_STATE3;
				tcs_pkg::TCS_DST_FINAL:  next_st.seq = tcs_pkg::TCS_SEQ_FINAL;
				default:                 next_st.seq = st.seq;
			endcase
		end

		// read data, valid only in the cycle after the strobe
		next_st.rdata = 8'h00;
		if (bus_i.rd)
		begin
			case (bus_i.addr)
				`TCS_OFS_CTRL1:
				begin
					next_st.rdata[`TCS_CTRL1_ARM_BIT]       = st.armed;
					next_st.rdata[`TCS_CTRL1_WIN_LSB +: 2] = st.window_selector;
				end
				`TCS_OFS_STATUS:
				begin
					next_st.rdata[`TCS_STATUS_FULL_BIT]     = st.trace_buffer_full_flag;
					next_st.rdata[`TCS_STATUS_SEQ_LSB +: 3] = st.seq;
				end
				`TCS_OFS_TRACE_CTRL:
				begin
					next_st.rdata[`TCS_TCTRL_ALIGN_LSB +: 2] = st.trigger_alignment_field;
				end
				`TCS_OFS_COUNT:
				begin
					// count is readable at any time, armed or not
					next_st.rdata = {1'b0, st.valid_line_tally};
				end
				`TCS_OFS_WINDOW:
				begin
					// other banks live outside this block and read as zero here
					if (st.window_selector == `TCS_WIN_STATE1)
					begin
						next_st.rdata = {4'h0, st.next_state_code};
					end
				end
				default:
				begin
					next_st.rdata = 8'h00;
				end
			endcase
		end

		// system reset keeps the captured count for post-mortem
		if (sys_rst_i)
		begin
			next_st.armed                   = 1'b0;
			next_st.window_selector         = `TCS_WIN_RST;
			next_st.trigger_alignment_field = `TCS_ALIGN_RST;
			next_st.next_state_code         = `TCS_CODE_RST;
			next_st.seq                     = tcs_pkg::TCS_SEQ_IDLE;
			next_st.valid_line_tally        = st.valid_line_tally;
			next_st.trace_buffer_full_flag  = st.trace_buffer_full_flag;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st.armed                   <= 1'b0;
			st.window_selector         <= `TCS_WIN_RST;
			st.trigger_alignment_field <= `TCS_ALIGN_RST;
			st.next_state_code         <= `TCS_CODE_RST;
			st.seq                     <= tcs_pkg::TCS_SEQ_IDLE;
			st.valid_line_tally        <= `TCS_CNT_RST;
			st.trace_buffer_full_flag  <= 1'b0;
			st.rdata                   <= 8'h00;
		end
		else if (ce_i)
		begin
			// a low enable freezes every field, read data included
			st <= next_st;
		end
	end

	assign rdata_o      = st.rdata;
	assign armed_o      = st.armed;
	assign line_count_o = st.valid_line_tally;
	assign full_o       = st.trace_buffer_full_flag;
	assign seq_state_o  = st.seq;

endmodule

// *** tb/tcs_match_src.sv ***
// comparator match source driving the sequencer channels
`timescale 1ns/1ns
module tcs_match_src
(
	// clock and request
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [3:0] pat_i,
	input  wire logic       slow_i,
	// match channels
	output logic [3:0]      match_o
);
	logic [3:0] fast_q;
	logic [3:0] slow_q;
	// one-cycle pulse; the slow path lands a cycle later
	always_ff @(posedge clk_i)
	begin
		fast_q <= go_i ? pat_i : 4'h0;
		slow_q <= fast_q;
	end
	assign match_o = slow_i ? slow_q : fast_q;
endmodule

// *** tb/tcs_top_assertions.sv ***
// port assertions of the trace count block
`timescale 1ns/1ns
`include "tcs_regs.svh"
module tcs_chk
#(
	parameter int NUM_CH = 4
)
(
	// clock, resets, bus
	input wire logic                  clk_i,
	input wire logic                  arst_n_i,
	input wire logic                  sys_rst_i,
	input wire logic                  ce_i,
	input wire tcs_pkg::tcs_bus_req_s bus_i,
	input wire logic [7:0]            rdata_o,
	// trace side and status
	input wire logic                  store_half_i,
	input wire logic                  trace_read_i,
	input wire logic [NUM_CH-1:0]     match_i,
	input wire logic                  armed_o,
	input wire logic [6:0]            line_count_o,
	input wire logic                  full_o,
	input wire tcs_pkg::tcs_seq_e     seq_state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	wire calm = ce_i && !sys_rst_i && !bus_i.wr;
	wire st   = calm && armed_o && store_half_i;

	a_count_step:
		assert property (st |=> line_count_o == 7'($past(line_count_o) + 7'h01))
		else $error("count did not step");
	a_wrap_full:
		assert property (st && line_count_o == 7'h7F |=> full_o && line_count_o == 7'h00)
		else $error("wrap did not set full");
	a_arm_clear:
		assert property (ce_i && !sys_rst_i && !store_half_i && bus_i.wr
			&& bus_i.addr == `TCS_OFS_CTRL1 && bus_i.wdata[7]
			|=> line_count_o == 7'h00 && !full_o && armed_o)
		else $error("arming did not clear count");
	a_sys_keep:
		assert property (ce_i && sys_rst_i && !store_half_i |=> $stable(line_count_o) && !armed_o)
		else $error("system reset touched count");
	a_count_hold:
		assert property (ce_i && !store_half_i && !bus_i.wr |=> $stable(line_count_o))
		else $error("count moved without store");
	a_ce_freeze:
		assert property (!ce_i |=> $stable(line_count_o) && $stable(full_o) && $stable(seq_state_o))
		else $error("state moved while disabled");
	a_full_zero:
		assert property ($rose(full_o) |-> line_count_o == 7'h00)
		else $error("full rose off the wrap");
	a_rd_idle:
		assert property (!bus_i.rd |=> rdata_o == 8'h00)
		else $error("read data without read");
	a_seq_hold:
		assert property (seq_state_o == tcs_pkg::TCS_SEQ_STATE1 && match_i == '0 && calm
			&& !store_half_i |=> seq_state_o == tcs_pkg::TCS_SEQ_STATE1)
		else $error("sequencer moved without match");
	a_disarm_idle:
		assert property (ce_i && !sys_rst_i && bus_i.wr && bus_i.addr == `TCS_OFS_CTRL1
			&& !bus_i.wdata[`TCS_CTRL1_ARM_BIT]
			|=> seq_state_o == tcs_pkg::TCS_SEQ_IDLE && !armed_o)
		else $error("disarm did not park sequencer");
	a_seq_armed:
		assert property (seq_state_o != tcs_pkg::TCS_SEQ_IDLE |-> armed_o)
		else $error("sequencer active while disarmed");
endmodule

bind tcs_top tcs_chk #(.NUM_CH(NUM_CH)) u_tcs_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.sys_rst_i(sys_rst_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.store_half_i(store_half_i), .trace_read_i(trace_read_i), .match_i(match_i),
	.armed_o(armed_o), .line_count_o(line_count_o), .full_o(full_o),
	.seq_state_o(seq_state_o));

// *** tb/tcs_top_test.sv ***
// self-checking bench for the trace count block
`timescale 1ns/1ns
`include "tcs_regs.svh"
module tcs_top_test;
	logic                  clk_i = 0, arst_n_i = 0, sys_rst_i = 0, ce_i = 1;
	logic                  store_half_i = 0, trace_read_i = 0, go = 0, slow = 0;
	logic [3:0]            pat = 0, match;
	tcs_pkg::tcs_bus_req_s bus_i = '0;
	logic [7:0]            rdata_o;
	logic                  armed_o, full_o;
	logic [6:0]            line_count_o;
	tcs_pkg::tcs_seq_e     seq_state_o;
	int                    miscompares = 0, compares = 0, cyc = 0, cnt, full, arm;
	logic [31:0]           seed = 32'h7CC9, r;
	// per code, nibble i = destination of channel i: 2/3 state, 4 final
	logic [15:0]           dst [16] = '{16'h2222, 16'h3333, 16'h4444, 16'h0200, 16'h0300,
		16'h0400, 16'h0032, 16'h0034, 16'h0302, 16'h0304, 16'h3020, 16'h3040, 16'h0222,
		16'h0000, 16'h0000, 16'h0000};

	tcs_top #(.NUM_CH(4)) u_tcs_top (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.sys_rst_i(sys_rst_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.store_half_i(store_half_i), .trace_read_i(trace_read_i), .match_i(match),
		.armed_o(armed_o), .line_count_o(line_count_o), .full_o(full_o),
		.seq_state_o(seq_state_o));
	tcs_match_src u_tcs_match_src (.clk_i(clk_i), .go_i(go), .pat_i(pat),
		.slow_i(slow), .match_o(match));

	always #5 clk_i = ~clk_i;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// lower channels overwrite higher ones unless a final move is already chosen
	function automatic logic [2:0] nxt(int c, logic [3:0] m);
		logic [2:0] x = 3'd1;
		for (int i = 3; i >= 0; i--)
			if (m[i] && dst[c][4*i+:3] != 0 && x != 3'd4)
				x = dst[c][4*i+:3];
		return x;
	endfunction

	task automatic check(string n, logic [7:0] s, logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_i);
		bus_i <= '{1'b1, 1'b0, a, d};
		@(posedge clk_i);
		bus_i <= '0;
	endtask

	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		bus_i <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_i);
		bus_i <= '0;
		#1 d = rdata_o;
	endtask

	task automatic finish_test();
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end

	initial
	begin
		logic [7:0] d;
		logic [2:0] e;
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1;
		repeat (3) @(posedge clk_i);
		rd(8'h3F, d);
		check("unmapped", d, 8'h00);
		for (int c = 0; c < 16; c++)
			for (int m = 1; m < 16; m++)
			begin
				wr(`TCS_OFS_CTRL1, 8'h00);
				wr(`TCS_OFS_WINDOW, 8'(c));
				rd(`TCS_OFS_WINDOW, d);
				check("code", d, 8'(c));
				wr(`TCS_OFS_CTRL1, 8'h80);
				@(posedge clk_i);
				go <= 1;
				pat <= 4'(m);
				r = rnd();
				slow <= r[0];
				@(posedge clk_i);
				go <= 0;
				repeat (3) @(posedge clk_i);
				e = nxt(c, 4'(m));
				#1 check("seq", 8'(seq_state_o), {5'h00, e});
				rd(`TCS_OFS_STATUS, d);
				check("seq status", d, {5'h00, e});
			end
		wr(`TCS_OFS_WINDOW, 8'h03);
		wr(`TCS_OFS_CTRL1, 8'h01);
		rd(`TCS_OFS_WINDOW, d);
		check("window1", d, 8'h00);
		wr(`TCS_OFS_CTRL1, 8'h00);
		rd(`TCS_OFS_WINDOW, d);
		check("armed write", d, 8'h0F);
		for (int a = 0; a < 3; a++)
		begin
			wr(`TCS_OFS_TRACE_CTRL, 8'(a));
			wr(`TCS_OFS_CTRL1, 8'h80);
			cnt = 0;
			full = 0;
			arm = 1;
			repeat (400)
			begin
				@(posedge clk_i);
				r = rnd();
				store_half_i <= r[0] | r[1];
				ce_i <= r[4:2] != 0;
				trace_read_i <= r[5];
				#1 check("count", 8'(line_count_o), 8'(cnt));
				check("full", 8'(full_o), 8'(full));
				check("armed", 8'(armed_o), 8'(arm));
				if (r[4:2] != 0 && arm == 1 && (r[0] | r[1]))
				begin
					cnt = (cnt + 1) % 128;
					full = cnt == 0 ? 1 : full;
					arm = cnt == 0 && a == 1 ? 0 : arm;
				end
			end
			@(posedge clk_i);
			store_half_i <= 0;
			ce_i <= 1;
			sys_rst_i <= 1;
			@(posedge clk_i);
			sys_rst_i <= 0;
			rd(`TCS_OFS_COUNT, d);
			check("kept count", d, 8'(cnt));
			rd(`TCS_OFS_STATUS, d);
			check("status", d, 8'(full << 7));
		end
		finish_test();
	end
endmodule
